//--- shared/pbgi_pkg.sv
/*
 * Constants, register map and state type for the press-brake guard interlock.
 * Assumes a 20 MHz scan clock and a classic Wishbone slave with 32-bit data.
 */
// What this block does
// RULE_01: With the guarding mode select low, all six guard outputs are held low.
// RULE_02: With the guarding mode select high, the receiver power output is on.
// RULE_03: While the guard reports set-up mode, the transmitter is on and closing enable is low.
// RULE_04: When set-up mode drops with no downward request, the transmitter turns off.
// RULE_05: A downward request turns the transmitter on and, with antivalent channels, closing enable.
// RULE_06: A creep feed request waits for the creep position feedback before telling the guard.
// RULE_07: Feedback during a creep feed request raises the creep muting request output.
// RULE_08: Guard muting active turns on the muting lamp.
// RULE_09: A beam interruption while guard muting is present keeps closing enable asserted.
// RULE_10: When guard muting goes away, closing enable drops; the code keeps it high when channel one is low and channel two high.
// RULE_11: Channel one high with channel two low and no muting forces enable low and flags it.
// RULE_12: Equal guard channels while guarding is enabled is a fault and holds enable low; the code sets no fault while set-up mode is active.
// RULE_13: The fault output latches and only a power cycle (reset) clears it.
// RULE_14: A start flag is set when the downward request is detected.
// RULE_15: Three sequence timers run with configurable times, each with its own started flag.
// RULE_16: The downward request comes from an already evaluated two-channel foot switch.
// RULE_17: Outputs are evaluated once per scan from inputs sampled in that scan.
package pbgi_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PBGI_STATUS_ADDR  = 8'h00;
    localparam logic [7:0] PBGI_MASK_ADDR    = 8'h04;
    localparam logic [7:0] PBGI_OUTPUTS_ADDR = 8'h08;
    localparam logic [7:0] PBGI_TIMER0_ADDR  = 8'h0C;
    localparam logic [7:0] PBGI_TIMER1_ADDR  = 8'h10;
    localparam logic [7:0] PBGI_TIMER2_ADDR  = 8'h14;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int PBGI_ST_INTERRUPTED = 0;
    localparam int PBGI_ST_START       = 1;
    localparam int PBGI_ST_T1_STARTED  = 2;
    localparam int PBGI_ST_T2_STARTED  = 3;
    localparam int PBGI_ST_T3_STARTED  = 4;
    localparam int PBGI_ST_FAULT       = 5;
    localparam int PBGI_ST_WIDTH       = 6;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [5:0]  PBGI_STATUS_RST = 6'h00;
    localparam logic [5:0]  PBGI_MASK_RST   = 6'h00;
    localparam int          PBGI_CLK_HZ     = 20_000_000;
    localparam int          PBGI_TICK_US    = 10_000;
    localparam int          PBGI_TICK_CYC   = PBGI_CLK_HZ / 1_000_000 * PBGI_TICK_US;
    localparam logic [15:0] PBGI_TIMER_RST  = 16'h0001;

    typedef enum logic [1:0] {
        PBGI_CREEP_IDLE,
        PBGI_CREEP_WAIT,
        PBGI_CREEP_MUTE
    } pbgi_creep_type;

endpackage

//--- src/pbgi_interlock.sv
/*
 * Press-brake guard interlock: guard power, closing enable, creep muting,
 * latched antivalence fault, event flags, three sequence timers, Wishbone slave.
 * Assumes guard and control inputs are asynchronous and the foot switch
 * request is already evaluated for two channels upstream.
 */
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ns
module pbgi_interlock #(
    parameter int TIMER_W  = 16,                         // Sequence timer width in bits
    parameter int TICK_CYC = pbgi_pkg::PBGI_TICK_CYC     // Clocks per timer tick
) (
    input  wire logic        clock,                      // 20 MHz scan clock
    input  wire logic        rst_n,                      // Synchronous reset, power-up only
    input  wire logic [7:0]  wb_adr_i,                   // Wishbone byte address
    input  wire logic [31:0] wb_dat_i,                   // Wishbone write data
    output logic [31:0]      wb_dat_o,                   // Wishbone read data
    input  wire logic        wb_we_i,                    // Wishbone write enable
    input  wire logic [3:0]  wb_sel_i,                   // Wishbone byte selects
    input  wire logic        wb_cyc_i,                   // Wishbone cycle
    input  wire logic        wb_stb_i,                   // Wishbone strobe
    output logic             wb_ack_o,                   // Wishbone acknowledge
    output logic             irq,                        // Level interrupt
    input  wire logic        guard_channel_one,          // Guard output channel 1
    input  wire logic        guard_channel_two,          // Guard output channel 2
    input  wire logic        guard_setup_mode_in,        // Guard set-up mode active
    input  wire logic        guard_muting_active_in,     // Guard muting active
    input  wire logic        guarding_mode_select,       // Operate with guard
    input  wire logic        creep_feed_request,         // Creep feed requested
    input  wire logic        creep_position_feedback,    // Creep position reached
    input  wire logic        downward_request,           // Close press request
    output logic             transmitter_power,          // Guard transmitter power
    output logic             receiver_power,             // Guard receiver power
    output logic             creep_muting_request,       // Muting request to guard
    output logic             muting_lamp,                // External muting lamp
    output logic             closing_enable,             // Closing movement enable
    output logic             latched_fault               // Latched fault
);
    import pbgi_pkg::*;

    localparam int NIN = 8;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NIN-1:0]          s1;
        logic [NIN-1:0]          s2;
        logic [NIN-1:0]          s3;
        logic [NIN-1:0]          inp;
        pbgi_creep_type          creep;
        logic                    tx;
        logic                    rx;
        logic                    cmr;
        logic                    lamp;
        logic                    en;
        logic                    fault;
        logic                    faultOut;
        logic                    dnPrev;
        logic [PBGI_ST_WIDTH-1:0] status;
        logic [PBGI_ST_WIDTH-1:0] mask;
        logic [2:0][TIMER_W-1:0] preset;
        logic [2:0][TIMER_W-1:0] count;
        logic [2:0]              run;
        logic [2:0]              done;
        logic [19:0]             tick;
        logic [31:0]             rdata;
        logic                    ack;
        logic                    irq;
    } pbgi_state_type;

    pbgi_state_type state_reg;
    pbgi_state_type state_next;

    // Input vector order
    localparam int CH1 = 0, CH2 = 1, SET = 2, MUT = 3, SEL = 4, CRP = 5, FBK = 6, DWN = 7;

    logic [NIN-1:0] rawIn;
    // Pins read directly so the assign follows every pin change
    assign rawIn = {downward_request, creep_position_feedback, creep_feed_request,
                    guarding_mode_select, guard_muting_active_in, guard_setup_mode_in,
                    guard_channel_two, guard_channel_one};

    always_comb begin
        logic [NIN-1:0]          stable;
        logic                    chOk;
        logic                    chEq;
        logic                    interrupted;
        logic                    startEv;
        logic [PBGI_ST_WIDTH-1:0] ev;
        logic                    acc;
        logic                    tickNow;
        logic [PBGI_ST_WIDTH-1:0] clr;
        stable      = '0;
        chOk        = 1'b0;
        chEq        = 1'b0;
        interrupted = 1'b0;
        startEv     = 1'b0;
        ev          = '0;
        acc         = 1'b0;
        tickNow     = 1'b0;
        clr         = '0;
        state_next  = state_reg;

        // --------------------------------------------------------
        // Input sampling: three stages, change counts on agreement
        // --------------------------------------------------------
        state_next.s1 = rawIn;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < NIN; i++) begin
            stable[i] = (state_reg.s2[i] == state_reg.s3[i]) ? state_reg.s3[i]
                                                               : state_reg.inp[i];
        end
        state_next.inp = stable;

        // --------------------------------------------------------
        // Scan evaluation from one sampled input set
        // --------------------------------------------------------
        chOk        = ~stable[CH1] & stable[CH2];                     // RULE_05
        chEq        = stable[CH1] == stable[CH2];
        interrupted = stable[CH1] & ~stable[CH2];
        startEv     = stable[DWN] & ~state_reg.dnPrev;
        state_next.dnPrev = stable[DWN];

        if (!stable[SEL]) begin
            state_next.tx    = 1'b0;                                  // RULE_01
            state_next.rx    = 1'b0;
            state_next.cmr   = 1'b0;
            state_next.lamp  = 1'b0;
            state_next.en    = 1'b0;
            state_next.creep = PBGI_CREEP_IDLE;
        end else begin
            state_next.rx   = 1'b1;                                   // RULE_02
            state_next.tx   = stable[SET] | stable[DWN];              // RULE_03 RULE_04 RULE_05
            state_next.lamp = stable[MUT];                            // RULE_08

            // Creep feed sequence
            unique case (state_reg.creep)
                PBGI_CREEP_IDLE:
                    if (stable[CRP]) begin
                        state_next.creep = PBGI_CREEP_WAIT;           // RULE_06
                    end
                PBGI_CREEP_WAIT:
                    if (!stable[CRP]) begin
                        state_next.creep = PBGI_CREEP_IDLE;
                    end else if (stable[FBK]) begin
                        state_next.creep = PBGI_CREEP_MUTE;           // RULE_07
                    end
                PBGI_CREEP_MUTE:
                    if (!stable[CRP] || !stable[FBK]) begin
                        state_next.creep = PBGI_CREEP_IDLE;
                    end
            endcase
            state_next.cmr = stable[CRP] && stable[FBK] &&
                             state_reg.creep != PBGI_CREEP_IDLE;      // RULE_07

            // Enable: set by request on good channels, held through muting
            if (stable[SET] || !stable[DWN] || state_reg.fault || chEq) begin
                state_next.en = 1'b0;                                 // RULE_03 RULE_12
            end else if (chOk) begin
                state_next.en = 1'b1;                                 // RULE_05
            end else if (interrupted && stable[MUT]) begin
                state_next.en = state_reg.en;                         // RULE_09
            end else begin
                state_next.en = 1'b0;                                 // RULE_11
            end
            if (state_reg.inp[MUT] && !stable[MUT] && !chOk) begin
                state_next.en = 1'b0;                                 // RULE_10
            end
            if (chEq && !stable[SET]) begin
                state_next.fault = 1'b1;                              // RULE_12 RULE_13
            end
        end
        // Only reset clears the fault; no other path drops it
        if (!stable[SEL]) begin
            state_next.fault = state_reg.fault;                       // RULE_13
        end
        // Pin shows the latch only in guarding mode, straight from a flop
        state_next.faultOut = state_next.fault && stable[SEL];       // RULE_01 RULE_13

        // --------------------------------------------------------
        // Sequence timers, 10 ms ticks
        // --------------------------------------------------------
        tickNow = state_reg.tick == 20'(TICK_CYC - 1);
        state_next.tick = tickNow ? '0 : state_reg.tick + 20'd1;
        for (int t = 0; t < 3; t++) begin
            logic go;
            go = 1'b0;
            unique case (t)
                0:       go = startEv && stable[SEL];
                1:       go = state_reg.done[0];
                default: go = state_reg.done[1];
            endcase
            state_next.done[t] = 1'b0;
            if (go) begin
                state_next.run[t]   = 1'b1;                           // RULE_15
                state_next.count[t] = state_reg.preset[t];
                ev[PBGI_ST_T1_STARTED + t] = 1'b1;                    // RULE_15
            end else if (state_reg.run[t] && tickNow) begin
                if (state_reg.count[t] <= TIMER_W'(1)) begin
                    state_next.run[t]  = 1'b0;
                    state_next.done[t] = 1'b1;
                end else begin
                    state_next.count[t] = state_reg.count[t] - TIMER_W'(1);
                end
            end
        end

        ev[PBGI_ST_INTERRUPTED] = stable[SEL] && interrupted && !stable[MUT];   // RULE_11
        ev[PBGI_ST_START]       = stable[SEL] && startEv;                       // RULE_14
        ev[PBGI_ST_FAULT]       = state_next.fault;

        // --------------------------------------------------------
        // Wishbone slave, one wait state, ack for one cycle
        // --------------------------------------------------------
        acc = wb_cyc_i && wb_stb_i && !state_reg.ack;
        state_next.ack = acc;
        state_next.rdata = '0;
        if (acc && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                PBGI_STATUS_ADDR: clr = wb_dat_i[PBGI_ST_WIDTH-1:0];
                PBGI_MASK_ADDR:   state_next.mask = wb_dat_i[PBGI_ST_WIDTH-1:0];
                PBGI_TIMER0_ADDR: state_next.preset[0] = wb_dat_i[TIMER_W-1:0];
                PBGI_TIMER1_ADDR: state_next.preset[1] = wb_dat_i[TIMER_W-1:0];
                PBGI_TIMER2_ADDR: state_next.preset[2] = wb_dat_i[TIMER_W-1:0];
                default: ;
            endcase
        end
        if (acc && !wb_we_i) begin
            unique case (wb_adr_i)
                PBGI_STATUS_ADDR:  state_next.rdata = 32'(state_reg.status);
                PBGI_MASK_ADDR:    state_next.rdata = 32'(state_reg.mask);
                PBGI_OUTPUTS_ADDR: state_next.rdata = 32'({state_reg.inp, 2'b00,
                                       state_reg.fault, state_reg.en, state_reg.lamp,
                                       state_reg.cmr, state_reg.rx, state_reg.tx});
                PBGI_TIMER0_ADDR:  state_next.rdata = 32'(state_reg.preset[0]);
                PBGI_TIMER1_ADDR:  state_next.rdata = 32'(state_reg.preset[1]);
                PBGI_TIMER2_ADDR:  state_next.rdata = 32'(state_reg.preset[2]);
                default:           state_next.rdata = '0;
            endcase
        end
        // Set wins over clear; fault bit stays while the fault latch stays
        state_next.status = (state_reg.status & ~clr) | ev;
        state_next.irq = |(state_next.status & state_next.mask);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg        <= '0;
            state_reg.creep  <= PBGI_CREEP_IDLE;
            state_reg.status <= PBGI_STATUS_RST;
            state_reg.mask   <= PBGI_MASK_RST;
            state_reg.preset <= {3{TIMER_W'(PBGI_TIMER_RST)}};
        end else begin
            state_reg <= state_next;
        end
    end

    // RULE_16: request qualification is the controller's job upstream.
    // RULE_17: every output is registered once per clock from one input set.
    assign transmitter_power    = state_reg.tx;
    assign receiver_power       = state_reg.rx;
    assign creep_muting_request = state_reg.cmr;
    assign muting_lamp          = state_reg.lamp;
    assign closing_enable       = state_reg.en;
    assign latched_fault        = state_reg.faultOut;
    assign wb_dat_o             = state_reg.rdata;
    assign wb_ack_o             = state_reg.ack;
    assign irq                  = state_reg.irq;

endmodule

//--- tb/pbgi_guard_model.sv
/* Behavioural model of the optical guard on the far side of the interlock.
   Assumes the bench drives its beam, defect and muting-accept commands. */
`timescale 1ns/1ns
module pbgi_guard_model (
    input  wire logic receiver_power,         // Guard receiver supply
    input  wire logic creep_muting_request,   // Muting request from block
    input  wire logic blockBeam,              // Beam interrupted
    input  wire logic equalOut,               // Channel defect, both high
    input  wire logic allowMute,              // Guard accepts muting
    output logic      guard_channel_one,      // Channel 1
    output logic      guard_channel_two,      // Channel 2
    output logic      guard_muting_active_in  // Muting active
);
    // Unpowered receiver releases both channels to their pulled-down level
    assign guard_channel_one = receiver_power & (blockBeam | equalOut);
    assign guard_channel_two = receiver_power & ~blockBeam;
    assign guard_muting_active_in = creep_muting_request & allowMute;
endmodule

//--- tb/pbgi_interlock_props.sv
/* Port checker for the guard interlock.
   Assumes one scan clock and a 4-5 cycle input-to-output latency. */
`timescale 1ns/1ns
module pbgi_interlock_props (
    input wire logic clock,                   // Scan clock
    input wire logic rst_n,                   // Sync reset
    input wire logic guard_channel_one,       // In
    input wire logic guard_channel_two,       // In
    input wire logic guard_setup_mode_in,     // In
    input wire logic guard_muting_active_in,  // In
    input wire logic guarding_mode_select,    // In
    input wire logic creep_feed_request,      // In
    input wire logic creep_position_feedback, // In
    input wire logic downward_request,        // In
    input wire logic transmitter_power,       // Out
    input wire logic receiver_power,          // Out
    input wire logic creep_muting_request,    // Out
    input wire logic muting_lamp,             // Out
    input wire logic closing_enable,          // Out
    input wire logic latched_fault            // Out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Eight held samples outlast the input synchroniser and output register
    wire run = guarding_mode_select & ~guard_setup_mode_in;
    wire same = guard_channel_one ~^ guard_channel_two;
    // Muted press stroke with no fault cause, so only muting keeps the enable
    wire hold = run & downward_request & guard_muting_active_in & ~same & ~latched_fault;
    sequence offHeld;
        !guarding_mode_select [*8];
    endsequence
    sequence faultThenOn;
        latched_fault ##1 guarding_mode_select [*8];
    endsequence
    off_all_low_a: assert property (offHeld |-> !(transmitter_power | receiver_power
        | creep_muting_request | muting_lamp | closing_enable | latched_fault))
        else $error("output active with guarding off");
    setup_tx_a: assert property ((guarding_mode_select && guard_setup_mode_in) [*8]
        |-> transmitter_power && !closing_enable) else $error("set-up output wrong");
    tx_off_a: assert property ((run && !downward_request) [*8] |-> !transmitter_power)
        else $error("transmitter on without cause");
    creep_mute_a: assert property ((run && downward_request && creep_feed_request
        && creep_position_feedback) [*8] |-> creep_muting_request) else $error("no muting request");
    lamp_on_a: assert property ((run && guard_muting_active_in) [*8] |-> muting_lamp)
        else $error("muting lamp off");
    mute_hold_a: assert property ((closing_enable && hold) [*4] ##1 hold [*8]
        |-> closing_enable) else $error("enable lost while muted");
    mute_drop_a: assert property ((guarding_mode_select && !guard_muting_active_in
        && guard_channel_one && !guard_channel_two) [*8] |-> !closing_enable)
        else $error("enable kept through interruption");
    equal_fault_a: assert property ((run && same) [*8] |-> latched_fault && !closing_enable)
        else $error("equal channels not faulted");
    fault_latch_a: assert property (faultThenOn |-> latched_fault)
        else $error("fault cleared without reset");
endmodule
bind pbgi_interlock pbgi_interlock_props chk (.clock(clock), .rst_n(rst_n),
    .guard_channel_one(guard_channel_one), .guard_channel_two(guard_channel_two),
    .guard_setup_mode_in(guard_setup_mode_in), .guard_muting_active_in(guard_muting_active_in),
    .guarding_mode_select(guarding_mode_select), .creep_feed_request(creep_feed_request),
    .creep_position_feedback(creep_position_feedback), .downward_request(downward_request),
    .transmitter_power(transmitter_power), .receiver_power(receiver_power),
    .creep_muting_request(creep_muting_request), .muting_lamp(muting_lamp),
    .closing_enable(closing_enable), .latched_fault(latched_fault));

//--- tb/pbgi_interlock_tb.sv
/* Self-checking bench for the guard interlock with a guard sensor model.
   Assumes a 4-5 cycle input-to-output latency and a one-cycle bus answer. */
`timescale 1ns/1ns
module pbgi_interlock_tb;
    import pbgi_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  wbAdr = 8'h00;
    logic [31:0] wbDatI = 32'h0000_0000;
    logic [31:0] wbDatO, rd;
    logic [31:0] seed = 32'h0000_9d48;
    logic        wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbAck, irq;
    logic        modeSel = 1'b0, setupIn = 1'b0, creepReq = 1'b0, creepFb = 1'b0;
    logic        downReq = 1'b0; // Foot switch already evaluated upstream
    logic        blockBeam = 1'b0, equalOut = 1'b0, allowMute = 1'b0;
    logic        ch1, ch2, mutingIn;
    logic [5:0]  outs;
    int          n_fail = 0;
    int          compares = 0;

    always #25 clock = ~clock;

    pbgi_guard_model gm (.receiver_power(outs[1]), .creep_muting_request(outs[2]),
        .blockBeam(blockBeam), .equalOut(equalOut), .allowMute(allowMute),
        .guard_channel_one(ch1), .guard_channel_two(ch2), .guard_muting_active_in(mutingIn));
    // Short tick so all three sequence timers run within the bench
    pbgi_interlock #(.TICK_CYC(16)) uut (.clock(clock), .rst_n(rst_n),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(4'hF), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_ack_o(wbAck), .irq(irq), .guard_channel_one(ch1), .guard_channel_two(ch2),
        .guard_setup_mode_in(setupIn), .guard_muting_active_in(mutingIn),
        .guarding_mode_select(modeSel), .creep_feed_request(creepReq),
        .creep_position_feedback(creepFb), .downward_request(downReq),
        .transmitter_power(outs[0]), .receiver_power(outs[1]), .creep_muting_request(outs[2]),
        .muting_lamp(outs[3]), .closing_enable(outs[4]), .latched_fault(outs[5]));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Enable survives a blocked beam only while the guard mutes
    function automatic logic [31:0] expOuts(input logic flt);
        logic run, cm, mu;
        run = modeSel & ~setupIn;
        cm = run & downReq & creepReq & creepFb;
        mu = cm & allowMute;
        return {26'h000_0000, modeSel & flt, run & downReq & ~flt & ((~blockBeam & ~equalOut) | mu),
            run & mu, cm, modeSel, modeSel & (setupIn | downReq)};
    endfunction

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 16);
        rd = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'h0;
        if (n >= 16) chk(32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic step(input logic [7:0] v, input logic flt);
        @(posedge clock);
        {modeSel, setupIn, downReq, creepReq, creepFb, blockBeam, equalOut, allowMute} <= v;
        repeat (12) @(posedge clock);
        @(negedge clock);
        chk(expOuts(flt), {26'h000_0000, outs});
    endtask

    task automatic wrap_up;
        $display("mismatches %0d of %0d compares", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        wb(1'b0, PBGI_STATUS_ADDR, 32'h0000_0000);
        chk({26'h000_0000, PBGI_STATUS_RST}, rd);
        wb(1'b0, PBGI_TIMER0_ADDR, 32'h0000_0000);
        chk({16'h0000, PBGI_TIMER_RST}, rd);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk(32'h0000_0000, rd);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            step({1'b0, seed[6:0]}, 1'b0);
        end
        step(8'hC0, 1'b0);
        step(8'h80, 1'b0);
        wb(1'b1, PBGI_MASK_ADDR, 32'h0000_0002);
        wb(1'b1, PBGI_TIMER1_ADDR, 32'h0000_0003);
        wb(1'b0, PBGI_TIMER1_ADDR, 32'h0000_0000);
        chk(32'h0000_0003, rd);
        step(8'hA0, 1'b0);
        wb(1'b0, PBGI_STATUS_ADDR, 32'h0000_0000);
        chk(32'h0000_0006, rd & 32'h0000_0007);
        chk(32'h0000_0001, {31'h0000_0000, irq});
        wb(1'b1, PBGI_STATUS_ADDR, 32'h0000_0002);
        wb(1'b0, PBGI_STATUS_ADDR, 32'h0000_0000);
        chk(32'h0000_0004, rd & 32'h0000_0007);
        chk(32'h0000_0000, {31'h0000_0000, irq});
        step(8'hB0, 1'b0);
        step(8'hB8, 1'b0);
        step(8'hB9, 1'b0);
        step(8'hBD, 1'b0);
        step(8'hA5, 1'b0);
        wb(1'b0, PBGI_STATUS_ADDR, 32'h0000_0000);
        chk(32'h0000_001D, rd & 32'h0000_001F);
        step(8'h80, 1'b0);
        wb(1'b1, PBGI_OUTPUTS_ADDR, 32'hFFFF_FFFF);
        wb(1'b0, PBGI_OUTPUTS_ADDR, 32'h0000_0000);
        chk(expOuts(1'b0), rd & 32'h0000_003F);
        step(8'h82, 1'b1);
        step(8'hA0, 1'b1);
        wb(1'b1, PBGI_STATUS_ADDR, 32'h0000_003F);
        wb(1'b0, PBGI_STATUS_ADDR, 32'h0000_0000);
        chk(32'h0000_0020, rd & 32'h0000_0020);
        chk(32'h0000_0000, {31'h0000_0000, irq});
        step(8'h00, 1'b1);
        step(8'hC0, 1'b1);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        step(8'hC0, 1'b0);
        wrap_up();
    end
endmodule
